// [hw/bcl_pkg.sv]
package bcl_pkg;
  localparam int REG_AW = 16;
  localparam int REG_DW = 8;
  localparam int CFG_AW = 9;
  localparam int CFG_DEPTH = 512;

  // Clock rates and the cycle counts derived from them
  localparam int SYS_MHZ = 100;
  localparam int FLASH_SLOW_MHZ = 30;
  localparam int FLASH_FAST_MHZ = 60;
  localparam int FLASH_SLOW_HALF = (SYS_MHZ + 2 * FLASH_SLOW_MHZ - 1) / (2 * FLASH_SLOW_MHZ);
  localparam int FLASH_FAST_HALF = (SYS_MHZ + 2 * FLASH_FAST_MHZ - 1) / (2 * FLASH_FAST_MHZ);
  localparam int EE_KHZ = 100;
  localparam int EE_QUARTER = (SYS_MHZ * 1000 + 4 * EE_KHZ - 1) / (4 * EE_KHZ);
  localparam int STRAP_SETTLE = 4;

  // Register map
  localparam logic [REG_AW-1:0] REG_FLASH_CTL = 16'h2400;
  localparam logic [REG_AW-1:0] REG_BOOT_CTL = 16'h2401;
  localparam logic [REG_DW-1:0] FLASH_CTL_RESET = 8'h02;
  localparam logic [REG_DW-1:0] BOOT_CTL_RESET = 8'h00;
  localparam int FC_SPEED_BIT = 0;
  localparam int FC_CS_IDLE_BIT = 1;
  localparam int FC_EXEC_BIT = 2;
  localparam int FC_EE_BIT = 3;
  localparam int FC_DONE_BIT = 4;
  localparam int BC_DUAL_BIT = 0;
  localparam int BC_MODE3_BIT = 1;
  localparam int BC_RERUN_BIT = 7;

  // Serial flash probe
  localparam logic [7:0] FLASH_CMD_READ = 8'h03;
  localparam logic [7:0] FLASH_CMD_DUAL = 8'h3b;
  localparam logic [23:0] FLASH_SIG_ADDR = 24'h00fffa;
  localparam logic [23:0] FLASH_EXEC_ADDR = 24'h000000;
  localparam logic [31:0] FLASH_SIG = 32'h32444655;
  localparam logic [9:0] FLASH_CMD_BITS = 10'd32;
  localparam logic [9:0] FLASH_DUMMY_BITS = 10'd8;
  localparam logic [9:0] FLASH_SINGLE_CLKS = 10'd32;
  localparam logic [9:0] FLASH_DUAL_CLKS = 10'd16;

  // Two-wire configuration memory
  localparam logic [7:0] EE_DEV_WR = 8'ha0;
  localparam logic [7:0] EE_DEV_RD = 8'ha1;
  localparam logic [7:0] EE_START_ADDR = 8'h00;
  localparam logic [9:0] EE_LAST = 10'd511;
  localparam logic [8:0] EE_SIG1_BASE = 9'h0fc;
  localparam logic [8:0] EE_SIG2_BASE = 9'h17c;
  localparam logic [31:0] EE_SIG1 = 32'h61746132;
  localparam logic [31:0] EE_SIG2 = 32'h65636631;
  localparam logic [2:0] OP_START0 = 3'h0;
  localparam logic [2:0] OP_DEVW = 3'h1;
  localparam logic [2:0] OP_ADDR = 3'h2;
  localparam logic [2:0] OP_START1 = 3'h3;
  localparam logic [2:0] OP_DEVR = 3'h4;
  localparam logic [2:0] OP_READ = 3'h5;
  localparam logic [2:0] OP_STOP = 3'h6;

  typedef enum logic [4:0] {
    ST_STRAP = 5'h01,
    ST_FLASH = 5'h02,
    ST_FCHK = 5'h04,
    ST_EE = 5'h08,
    ST_DONE = 5'h10
  } bcl_state_t;
endpackage

// [hw/bcl_sync.sv]
`timescale 1ns/1ps
module bcl_sync #(
  parameter int W = 2
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } bcl_sync_t;

  bcl_sync_t syncReg;
  bcl_sync_t syncNext;

  always_comb begin
    syncNext.s1 = d;
    syncNext.s2 = syncReg.s1;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      syncReg <= '0;
    end else begin
      syncReg <= syncNext;
    end
  end

  assign q = syncReg.s2;
endmodule

// [hw/bcl_cfg_mem.sv]
`timescale 1ns/1ps
module bcl_cfg_mem (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic we,
  input wire logic [bcl_pkg::CFG_AW-1:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic [bcl_pkg::CFG_AW-1:0] rdAddr,
  output logic [7:0] rdData
);
  import bcl_pkg::*;

  // Array left without reset so it maps onto a plain RAM
  logic [7:0] mem [CFG_DEPTH];
  logic [7:0] rdReg;

  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdReg <= 8'h00;
    end else begin
      rdReg <= mem[rdAddr];
    end
  end

  assign rdData = rdReg;
endmodule

// [hw/bcl_boot_loader.sv]
// Design decision made here: strobed register access.
`timescale 1ns/1ps
module bcl_boot_loader (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [bcl_pkg::REG_AW-1:0] regAddr,
  input wire logic [bcl_pkg::REG_DW-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [bcl_pkg::REG_DW-1:0] regRdData,
  input wire logic suspend,
  input wire logic [bcl_pkg::CFG_AW-1:0] cfgRdAddr,
  output logic [7:0] cfgRdData,
  output logic cfgValid,
  output logic execFromFlash,
  output logic bootDone,
  output logic hubAttach,
  output logic flashCsN,
  output logic flashClkOut,
  output logic flashClkOeN,
  output logic strapIoOut,
  output logic strapIoOeN,
  input wire logic strapIoIn,
  output logic strapIoPullDown,
  input wire logic flashDataIn,
  output logic flashDataInPullDown
);
  import bcl_pkg::*;

  typedef struct packed {
    bcl_state_t st;
    logic [9:0] cnt;
    logic [8:0] div;
    logic [3:0] bits;
    logic [1:0] q;
    logic [2:0] op;
    logic [31:0] shift;
    logic [1:0] smp;
    logic sck, sckOeN, csN;
    logic sdo, sdoOeN, sdoPd, diPd;
    logic speed, dual, mode3;
    logic execFlash, eeValid, sigOk, attach, done;
    logic [7:0] rdData;
    logic memWe;
    logic [8:0] memAddr;
    logic [7:0] memWd;
  } bcl_core_t;

  bcl_core_t coreReg;
  bcl_core_t coreNext;
  logic [1:0] pinSync;
  logic strapS;
  logic diS;
  logic tick;
  logic [8:0] reload;
  logic [9:0] dataStart;
  logic [9:0] totalClks;
  logic [7:0] status;

  // Shared strap/data-out pin and data-in pin come from outside the clock domain
  bcl_sync #(.W(2)) u_sync (
    .clk_sys(clk_sys), .resetn(resetn), .d({flashDataIn, strapIoIn}), .q(pinSync)
  );
  assign strapS = pinSync[0];
  assign diS = pinSync[1];

  bcl_cfg_mem u_mem (
    .clk_sys(clk_sys), .resetn(resetn), .we(coreReg.memWe), .wrAddr(coreReg.memAddr),
    .wrData(coreReg.memWd), .rdAddr(cfgRdAddr), .rdData(cfgRdData)
  );

  function automatic logic [8:0] eeSigByte(input logic [8:0] a);
    logic [4:0] sh;
    sh = {~a[1:0], 3'h0};
    if (a[8:2] == EE_SIG1_BASE[8:2]) begin
      eeSigByte = {1'b1, 8'(EE_SIG1 >> sh)};
    end else if (a[8:2] == EE_SIG2_BASE[8:2]) begin
      eeSigByte = {1'b1, 8'(EE_SIG2 >> sh)};
    end else begin
      eeSigByte = 9'h000;
    end
  endfunction

  assign status = {3'h0, coreReg.done, coreReg.eeValid, coreReg.execFlash, coreReg.csN,
                   coreReg.speed};
  assign tick = (coreReg.div == 9'h000);
  assign reload = (coreReg.st == ST_EE) ? 9'(EE_QUARTER - 1) :
                  coreReg.speed ? 9'(FLASH_FAST_HALF - 1) :
                  9'(FLASH_SLOW_HALF - 1);
  assign dataStart = coreReg.dual ? FLASH_CMD_BITS + FLASH_DUMMY_BITS : FLASH_CMD_BITS;
  assign totalClks = dataStart + (coreReg.dual ? FLASH_DUAL_CLKS : FLASH_SINGLE_CLKS);

  always_comb begin
    logic startFlash;
    logic [8:0] chk;
    logic [7:0] opByte;
    startFlash = 1'b0;
    chk = eeSigByte(coreReg.cnt[8:0]);
    opByte = (coreReg.op == OP_DEVW) ? EE_DEV_WR :
             (coreReg.op == OP_ADDR) ? EE_START_ADDR : EE_DEV_RD;
    coreNext = coreReg;
    coreNext.memWe = 1'b0;
    coreNext.smp = {coreReg.smp[0], 1'b0};
    coreNext.div = tick ? reload : coreReg.div - 9'h001;
    coreNext.rdData = 8'h00;
    if (regRd && regAddr == REG_FLASH_CTL) begin
      coreNext.rdData = status;
    end else if (regRd && regAddr == REG_BOOT_CTL) begin
      coreNext.rdData = {6'h00, coreReg.mode3, coreReg.dual};
    end
    if (regWr && regAddr == REG_BOOT_CTL) begin
      coreNext.dual = regWrData[BC_DUAL_BIT];
      coreNext.mode3 = regWrData[BC_MODE3_BIT];
      startFlash = regWrData[BC_RERUN_BIT] && coreReg.st == ST_DONE;
    end
    // Synchroniser adds two cycles, so samples are taken two cycles after the rising edge
    if (coreReg.smp[1]) begin
      coreNext.shift = coreReg.dual ? {coreReg.shift[29:0], diS, strapS}
                                    : {coreReg.shift[30:0], diS};
    end
    unique case (coreReg.st)
      ST_STRAP: begin
        coreNext.cnt = coreReg.cnt + 10'd1;
        if (coreReg.cnt == 10'(STRAP_SETTLE)) begin
          coreNext.speed = strapS;
          coreNext.sdoPd = 1'b0;
          startFlash = 1'b1;
        end
      end
      ST_FLASH: begin
        if (tick && !coreReg.sck) begin
          coreNext.sck = 1'b1;
          coreNext.cnt = coreReg.cnt + 10'd1;
          if (coreReg.cnt >= dataStart) begin
            coreNext.smp = {coreReg.smp[0], 1'b1};
          end
        end else if (tick && coreReg.cnt == totalClks) begin
          coreNext.sck = coreReg.mode3;
          coreNext.st = ST_FCHK;
        end else if (tick) begin
          coreNext.sck = 1'b0;
          if (coreReg.cnt != 10'd0 && coreReg.cnt < FLASH_CMD_BITS) begin
            coreNext.shift = {coreReg.shift[30:0], 1'b0};
            coreNext.sdo = coreReg.shift[30];
          end else if (coreReg.cnt >= FLASH_CMD_BITS && coreReg.dual) begin
            coreNext.sdoOeN = 1'b1;
          end
        end
      end
      ST_FCHK: begin
        if (coreReg.smp == 2'b00) begin
          coreNext.csN = 1'b1;
          coreNext.sdoOeN = 1'b0;
          coreNext.sdo = 1'b0;
          if (coreReg.shift == FLASH_SIG) begin
            coreNext.execFlash = 1'b1;
            coreNext.st = ST_DONE;
          end else begin
            coreNext.st = ST_EE;
            coreNext.op = OP_START0;
            coreNext.q = 2'h0;
            coreNext.bits = 4'h0;
            coreNext.cnt = 10'd0;
            coreNext.sigOk = 1'b1;
            coreNext.sck = 1'b0;
            coreNext.sckOeN = 1'b1;
            coreNext.sdoOeN = 1'b1;
          end
        end
      end
      ST_EE: begin
        if (tick) begin
          coreNext.q = coreReg.q + 2'h1;
          if (coreReg.op == OP_START0 || coreReg.op == OP_START1) begin
            if (coreReg.q == 2'h0) begin
              coreNext.sdoOeN = 1'b1;
              coreNext.sckOeN = 1'b1;
            end else if (coreReg.q == 2'h2) begin
              coreNext.sdoOeN = 1'b0;
            end else if (coreReg.q == 2'h3) begin
              coreNext.sckOeN = 1'b0;
              coreNext.op = coreReg.op + 3'h1;
            end
          end else if (coreReg.op == OP_STOP) begin
            if (coreReg.q == 2'h0) begin
              coreNext.sdoOeN = 1'b0;
              coreNext.sckOeN = 1'b0;
            end else if (coreReg.q == 2'h1) begin
              coreNext.sckOeN = 1'b1;
            end else if (coreReg.q == 2'h2) begin
              coreNext.sdoOeN = 1'b1;
            end else begin
              coreNext.eeValid = coreReg.sigOk;
              coreNext.st = ST_DONE;
            end
          end else begin
            if (coreReg.q == 2'h0) begin
              coreNext.sckOeN = 1'b0;
              if (coreReg.op == OP_READ) begin
                coreNext.sdoOeN = coreReg.bits != 4'h8 || coreReg.cnt == EE_LAST;
              end else begin
                coreNext.sdoOeN = coreReg.bits == 4'h8 ||
                                  opByte[3'h7 - coreReg.bits[2:0]];
              end
            end else if (coreReg.q == 2'h1) begin
              coreNext.sckOeN = 1'b1;
            end else if (coreReg.q == 2'h2) begin
              if (coreReg.op != OP_READ && coreReg.bits == 4'h8 && strapS) begin
                // No acknowledge: nothing on the bus, fall back to defaults
                coreNext.st = ST_DONE;
                coreNext.sckOeN = 1'b1;
                coreNext.sdoOeN = 1'b1;
              end else if (coreReg.op == OP_READ && coreReg.bits != 4'h8) begin
                coreNext.shift[7:0] = {coreReg.shift[6:0], strapS};
              end
            end else begin
              coreNext.sckOeN = 1'b0;
              coreNext.bits = (coreReg.bits == 4'h8) ? 4'h0 : coreReg.bits + 4'h1;
              if (coreReg.bits == 4'h8 && coreReg.op != OP_READ) begin
                coreNext.op = coreReg.op + 3'h1;
              end else if (coreReg.bits == 4'h8) begin
                coreNext.memWe = 1'b1;
                coreNext.memAddr = coreReg.cnt[8:0];
                coreNext.memWd = coreReg.shift[7:0];
                if (chk[8] && chk[7:0] != coreReg.shift[7:0]) begin
                  coreNext.sigOk = 1'b0;
                end
                coreNext.cnt = coreReg.cnt + 10'd1;
                if (coreReg.cnt == EE_LAST) begin
                  coreNext.op = OP_STOP;
                end
              end
            end
          end
        end
      end
      ST_DONE: begin
        coreNext.attach = 1'b1;
        coreNext.done = 1'b1;
        coreNext.csN = 1'b1;
        if (coreReg.eeValid) begin
          coreNext.sckOeN = 1'b1;
          coreNext.sdoOeN = 1'b1;
        end else if (suspend) begin
          coreNext.sckOeN = 1'b0;
          coreNext.sdo = 1'b0;
          coreNext.sdoOeN = coreReg.speed;
        end else begin
          coreNext.sck = coreReg.mode3;
          coreNext.sckOeN = 1'b0;
          coreNext.sdoOeN = 1'b0;
        end
      end
    endcase
    if (startFlash) begin
      coreNext.st = ST_FLASH;
      coreNext.cnt = 10'd0;
      coreNext.div = reload;
      coreNext.smp = 2'b00;
      coreNext.csN = 1'b0;
      coreNext.sck = coreNext.mode3;
      coreNext.sckOeN = 1'b0;
      coreNext.sdoOeN = 1'b0;
      coreNext.execFlash = 1'b0;
      coreNext.eeValid = 1'b0;
      coreNext.attach = 1'b0;
      coreNext.done = 1'b0;
      // Control bits written together with the rerun request already shape this probe
      coreNext.shift = {coreNext.dual ? FLASH_CMD_DUAL : FLASH_CMD_READ, FLASH_SIG_ADDR};
      coreNext.sdo = coreNext.shift[31];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      coreReg <= '0;
      coreReg.st <= ST_STRAP;
      coreReg.csN <= 1'b1;
      coreReg.sdoOeN <= 1'b1;
      coreReg.sdoPd <= 1'b1;
      coreReg.diPd <= 1'b1;
    end else begin
      coreReg <= coreNext;
    end
  end

  assign regRdData = coreReg.rdData;
  assign cfgValid = coreReg.eeValid;
  assign execFromFlash = coreReg.execFlash;
  assign bootDone = coreReg.done;
  assign hubAttach = coreReg.attach;
  assign flashCsN = coreReg.csN;
  assign flashClkOut = coreReg.sck;
  assign flashClkOeN = coreReg.sckOeN;
  assign strapIoOut = coreReg.sdo;
  assign strapIoOeN = coreReg.sdoOeN;
  assign strapIoPullDown = coreReg.sdoPd;
  assign flashDataInPullDown = coreReg.diPd;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  property p_strap_hold;
    coreReg.st == ST_STRAP |-> strapIoOeN && strapIoPullDown && flashCsN;
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap pin not released");
  property p_strap_latch;
    coreReg.st == ST_STRAP && coreReg.cnt == 10'(STRAP_SETTLE) |=>
      coreReg.speed == $past(strapS) && !strapIoPullDown && coreReg.st == ST_FLASH;
  endproperty
  a_strap_latch: assert property (p_strap_latch) else $error("strap not latched");
  property p_ctl_read;
    regRd && regAddr == REG_FLASH_CTL && coreReg.st == ST_STRAP |=>
      regRdData == FLASH_CTL_RESET;
  endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("control reset value wrong");
  property p_slow_clock;
    coreReg.st == ST_FLASH && !coreReg.speed && $rose(flashClkOut) |=> flashClkOut;
  endproperty
  a_slow_clock: assert property (p_slow_clock) else $error("slow flash clock too fast");
  property p_cs_idle;
    coreReg.st != ST_FLASH && coreReg.st != ST_FCHK |-> flashCsN;
  endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("chip select low while idle");
  property p_flash_boot;
    coreReg.st == ST_FCHK && coreReg.smp == 2'b00 && coreReg.shift == FLASH_SIG |=>
      execFromFlash && coreReg.st == ST_DONE ##1 hubAttach;
  endproperty
  a_flash_boot: assert property (p_flash_boot) else $error("flash boot not taken");
  property p_fallback;
    coreReg.st == ST_FCHK && coreReg.smp == 2'b00 && coreReg.shift != FLASH_SIG |=>
      !execFromFlash && coreReg.st == ST_EE && flashClkOeN;
  endproperty
  a_fallback: assert property (p_fallback) else $error("no fallback to eeprom");
  property p_ee_result;
    coreReg.st == ST_EE && coreReg.op == OP_STOP && coreReg.q == 2'h3 && tick |=>
      cfgValid == $past(coreReg.sigOk) ##1 hubAttach && bootDone;
  endproperty
  a_ee_result: assert property (p_ee_result) else $error("eeprom result wrong");
  property p_suspend;
    coreReg.st == ST_DONE && !cfgValid && suspend |=> flashCsN &&
      (strapIoOeN == coreReg.speed) && !strapIoOut;
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspend pin state wrong");
endmodule

// [sim/bcl_flash_model.sv]
`timescale 1ns/1ps
module bcl_flash_model
  import bcl_pkg::*;
(
  input wire logic csN,
  input wire logic sck,
  input wire logic mosi,
  input wire logic present,
  input wire logic [31:0] sigWord,
  output logic diDrv,
  output logic diVal,
  output logic ioDrv,
  output logic ioVal,
  output logic [7:0] cmd,
  output logic [23:0] addr
);
  int cnt;
  logic [31:0] sh;
  wire csDly;

  // A clock edge launched together with the select fall is not a bit clock
  assign #1 csDly = csN;

  initial begin
    {diDrv, diVal, ioDrv, ioVal, cmd, addr, cnt, sh} = '0;
  end

  // Deselected lines fall back to the data-in pull-down and the board strap resistor
  always @(posedge csN) begin
    diDrv = 0;
    ioDrv = 0;
    cnt = 0;
  end

  // Rising edges sample and falling edges shift out, so mode 0 and mode 3 both work
  always @(posedge sck) begin
    if (!csN && !csDly) begin
      if (cnt < 32) sh = {sh[30:0], mosi};
      cnt = cnt + 1;
      if (cnt == 8) cmd = sh[7:0];
      if (cnt == 32) addr = sh[23:0];
    end
  end

  // Only the probe window of a part of 512 Kbit or more is modelled
  // Output delay keeps data stable across the following rising edge
  always @(negedge sck) begin
    if (!csN && present) begin
      #2;
      if (cmd == FLASH_CMD_READ && cnt >= 32 && cnt < 64) begin
        diDrv = 1;
        diVal = sigWord[63-cnt];
      end
      if (cmd == FLASH_CMD_DUAL && cnt >= 40 && cnt < 56) begin
        {diDrv, ioDrv} = 2'b11;
        {diVal, ioVal} = sigWord[2*(55-cnt)+:2];
      end
    end
  end
endmodule

// [sim/bcl_boot_loader_tb.sv]
`timescale 1ns/1ps
module bcl_boot_loader_tb;
  import bcl_pkg::*;
  logic clk_sys = 0;
  logic resetn = 0;
  logic [REG_AW-1:0] regAddr = '0;
  logic [REG_DW-1:0] regWrData = '0;
  logic regWr = 0;
  logic regRd = 0;
  logic suspend = 0;
  logic [CFG_AW-1:0] cfgRdAddr = '0;
  logic strapLvl = 1;
  logic present = 1;
  logic [31:0] sigWord = FLASH_SIG;
  logic [REG_DW-1:0] regRdData, rdv;
  logic [7:0] cfgRdData, cmd;
  logic [23:0] addr;
  logic cfgValid, execFromFlash, bootDone, hubAttach, flashCsN, flashClkOut, flashClkOeN;
  logic strapIoOut, strapIoOeN, strapIoIn, strapIoPullDown, flashDataIn, flashDataInPullDown;
  logic diDrv, diVal, ioDrv, ioVal;
  int errors = 0;
  int checkCount = 0;

  always #5 clk_sys = ~clk_sys;

  // Released pin shows the board strap resistor, which also pulls the two-wire data line
  assign strapIoIn = !strapIoOeN ? strapIoOut : (ioDrv ? ioVal : strapLvl);
  assign flashDataIn = diDrv ? diVal : 1'b0;

  bcl_boot_loader i_bcl_boot_loader (
    .clk_sys(clk_sys), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .suspend(suspend),
    .cfgRdAddr(cfgRdAddr), .cfgRdData(cfgRdData), .cfgValid(cfgValid),
    .execFromFlash(execFromFlash), .bootDone(bootDone), .hubAttach(hubAttach),
    .flashCsN(flashCsN), .flashClkOut(flashClkOut), .flashClkOeN(flashClkOeN),
    .strapIoOut(strapIoOut), .strapIoOeN(strapIoOeN), .strapIoIn(strapIoIn),
    .strapIoPullDown(strapIoPullDown), .flashDataIn(flashDataIn),
    .flashDataInPullDown(flashDataInPullDown)
  );

  bcl_flash_model i_bcl_flash_model (
    .csN(flashCsN), .sck(flashClkOut), .mosi(strapIoOut), .present(present),
    .sigWord(sigWord), .diDrv(diDrv), .diVal(diVal), .ioDrv(ioDrv), .ioVal(ioVal),
    .cmd(cmd), .addr(addr)
  );

  task automatic finishTest();
    $display("checks %0d mismatches %0d", checkCount, errors);
    if (errors == 0 && checkCount > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(logic [REG_AW-1:0] a, logic [REG_DW-1:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1;
    @(posedge clk_sys);
    regWr <= 0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(logic [REG_AW-1:0] a, output logic [REG_DW-1:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1;
    @(posedge clk_sys);
    regRd <= 0;
    #1;
    d = regRdData;
  endtask

  // Tracks the flash clock half period and whether the clock pin was ever released
  task automatic waitDone(output int half, output logic rel);
    int hc;
    logic had;
    logic pc;
    {half, rel, hc, had, pc} = '0;
    for (int n = 0; n < 30000 && bootDone !== 1'b1; n++) begin
      @(posedge clk_sys);
      #1;
      hc++;
      if (flashCsN === 1'b1) had = 0;
      if (flashClkOeN === 1'b1 && flashClkOut === 1'b0) rel = 1;
      if (flashClkOut !== pc) begin
        if (had) half = hc;
        had = 1;
        hc = 0;
      end
      pc = flashClkOut;
    end
    check("done", bootDone, 1);
  endtask

  task automatic boot(string name, logic s, logic [31:0] sig, logic ex);
    int half;
    logic rel;
    @(posedge clk_sys);
    resetn <= 0;
    strapLvl <= s;
    sigWord <= sig;
    repeat (4) @(posedge clk_sys);
    check("cs in reset", flashCsN, 1);
    check("clock in reset", {flashClkOut, flashClkOeN}, 0);
    check("strap pin in reset", {strapIoOeN, strapIoPullDown}, 2'b11);
    check("data-in pull-down", flashDataInPullDown, 1);
    resetn <= 1;
    rd(REG_FLASH_CTL, rdv);
    check("status at reset", rdv, FLASH_CTL_RESET);
    waitDone(half, rel);
    check("attach", {bootDone, hubAttach}, 2'b11);
    check("boot source", {execFromFlash, cfgValid}, {ex, 1'b0});
    check("pull-down off", strapIoPullDown, 0);
    rd(REG_FLASH_CTL, rdv);
    check("status", rdv, {3'h0, 2'b10, ex, 1'b1, s});
    check("half period", half, s ? FLASH_FAST_HALF : FLASH_SLOW_HALF);
    check("command address", {cmd, addr}, {FLASH_CMD_READ, FLASH_SIG_ADDR});
    if (!ex) check("two-wire clock released", rel, 1);
    @(posedge clk_sys);
    suspend <= 1;
    repeat (3) @(posedge clk_sys);
    #1;
    check("suspend cs", flashCsN, 1);
    check("suspend pin", {strapIoOeN, strapIoOut | s}, {s, s});
    @(posedge clk_sys);
    suspend <= 0;
    $display("test %s done", name);
  endtask

  initial begin
    logic [7:0] c;
    int half;
    logic rel;
    boot("fast flash", 1, FLASH_SIG, 1);
    wr(REG_FLASH_CTL, 8'hff);
    rd(16'h2402, rdv);
    check("unmapped read", rdv, 0);
    rd(REG_FLASH_CTL, rdv);
    check("status read-only", rdv, 8'h17);
    // Dual, mode 3, and both together, each with a fresh probe
    for (int m = 1; m < 4; m++) begin
      c = 8'(m);
      wr(REG_BOOT_CTL, 8'h80 | c);
      rd(REG_BOOT_CTL, rdv);
      check("control", rdv, c);
      waitDone(half, rel);
      check("rerun exec", execFromFlash, 1);
      check("rerun command", cmd, c[0] ? FLASH_CMD_DUAL : FLASH_CMD_READ);
    end
    $display("test modes done");
    boot("slow flash", 0, FLASH_SIG, 1);
    boot("bad signature", 1, ~FLASH_SIG, 0);
    finishTest();
  end

  initial begin
    #800000;
    errors++;
    $display("watchdog expired");
    finishTest();
  end
endmodule
